// ==== phy_ext_pkg.sv ====
package phy_ext_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [4:0] TEN_OPS_ADDR = 5'h12;
  localparam logic [4:0] EXT_CTRL_ADDR = 5'h13;

  // ****************************************************************
  // Ten-base operations field positions and reset value
  // ****************************************************************
  localparam int RJAB_BIT = 15;
  localparam int POL_BIT = 14;
  localparam int JAB_INH_BIT = 5;
  localparam int RSV4_BIT = 4;
  localparam int APOL_INH_BIT = 3;
  localparam int SQE_INH_BIT = 2;
  localparam int LINK_INH_BIT = 1;
  localparam int SQL_INH_BIT = 0;
  localparam logic [15:0] TEN_OPS_RESET = 16'h0010;
  localparam logic [15:0] TEN_OPS_WMASK = 16'h3fff;

  // ****************************************************************
  // Extended control field positions and reset value
  // ****************************************************************
  localparam int NODE_REP_BIT = 15;
  localparam int HWSW_BIT = 14;
  localparam int RFAULT_BIT = 13;
  localparam int TRI_BIT = 7;
  localparam int APD_BIT = 0;
  localparam logic [15:0] EXT_CTRL_RESET = 16'h0001;
  localparam logic [15:0] EXT_CTRL_WMASK = 16'h1bff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int SQE_PULSE_NS = 1000;
  localparam int SQE_PULSE_CYC = (SQE_PULSE_NS * CLK_MHZ) / 1000;

  // ****************************************************************
  // Grouped carriers
  // ****************************************************************
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic rx_pol_swapped;
    logic rx_valid_data;
    logic rx_idle;
    logic rx_link_pulse;
    logic rx_jabber;
    logic partner_fault;
    logic full_duplex;
    logic ten_mode;
  } line_stat_t;

  typedef struct packed {
    logic jabber_check_en;
    logic rx_pol_correct;
    logic link_pass;
    logic carrier_sense;
    logic collision;
    logic tx_tristate;
    logic tx100_power_down;
  } line_ctrl_t;

  typedef enum logic [1:0] {
    LNK_FAIL,
    LNK_WAIT_IDLE,
    LNK_PASS
  } link_state_t;

endpackage

// ==== phy_10base_ops_ext_ctrl_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

module phy_10base_ops_ext_ctrl_regs
  import phy_ext_pkg::*;
#(
  parameter int SQE_CYC = SQE_PULSE_CYC
) (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic sys_rst, // Synchronous active high reset
  input wire phy_ext_pkg::mgmt_req_t mgmt_req, // Management access request
  output logic [15:0] mgmt_rdata, // Read data, registered
  input wire phy_ext_pkg::line_stat_t line_stat, // Line status from datapath
  input wire logic node_repeater_select, // Configuration pin, async
  input wire logic sw_mode_pin, // Hardware/software mode pin, async
  input wire logic pair_transmit_pos_in, // Transmit positive from encoder
  input wire logic pair_transmit_neg_in, // Transmit negative from encoder
  output logic pair_transmit_pos, // Transmit positive pin level
  output logic pair_transmit_neg, // Transmit negative pin level
  output logic pair_transmit_oe_n, // Transmit pins enable, low drives
  output phy_ext_pkg::line_ctrl_t line_ctrl // Controls to datapath
);
  import phy_ext_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] node_sync_r;
  logic [1:0] swm_sync_r;
  logic [9:0] stat_s1_r;
  line_stat_t stat_r;

  always_ff @(posedge core_clk) begin
    node_sync_r <= {node_sync_r[0], node_repeater_select};
    swm_sync_r <= {swm_sync_r[0], sw_mode_pin};
    stat_s1_r <= line_stat;
    stat_r <= stat_s1_r;
  end

  // ****************************************************************
  // Strap capture after reset release
  // ****************************************************************
  logic rst_d_r;
  logic [1:0] strap_cnt_r;
  logic repeater_r;
  logic sw_mode_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_d_r <= 1'b1;
      strap_cnt_r <= 2'h0;
    end else begin
      rst_d_r <= 1'b0;
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      repeater_r <= 1'b0;
      sw_mode_r <= 1'b1;
    end else if (strap_cnt_r == 2'h2) begin
      repeater_r <= node_sync_r[1];
      sw_mode_r <= swm_sync_r[1];
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0] ten_ops_r;
  logic [15:0] ext_ctrl_r;
  logic pol_latch_r;
  logic rjab_latch_r;
  wire logic wr_ten = mgmt_req.wr && (mgmt_req.addr == TEN_OPS_ADDR);
  wire logic wr_ext = mgmt_req.wr && (mgmt_req.addr == EXT_CTRL_ADDR);
  wire logic rd_ten = mgmt_req.rd && (mgmt_req.addr == TEN_OPS_ADDR);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ten_ops_r <= TEN_OPS_RESET;
    end else if (wr_ten) begin
      // Reserved bits are stored as written; manager keeps defaults
      ten_ops_r <= mgmt_req.wdata & TEN_OPS_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_ctrl_r <= EXT_CTRL_RESET;
    end else if (wr_ext) begin
      ext_ctrl_r <= mgmt_req.wdata & EXT_CTRL_WMASK;
    end
  end

  // Latching-high status bits; a new event wins over the read clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pol_latch_r <= 1'b0;
      rjab_latch_r <= 1'b0;
    end else begin
      if (stat_r.rx_pol_swapped) begin
        pol_latch_r <= 1'b1;
      end else if (rd_ten) begin
        pol_latch_r <= 1'b0;
      end
      if (stat_r.rx_jabber) begin
        rjab_latch_r <= 1'b1;
      end else if (rd_ten) begin
        rjab_latch_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [15:0] ten_view;
  logic [15:0] ext_view;

  always_comb begin
    ten_view = ten_ops_r;
    ten_view[RJAB_BIT] = rjab_latch_r;
    ten_view[POL_BIT] = pol_latch_r | stat_r.rx_pol_swapped;
    ext_view = ext_ctrl_r;
    ext_view[NODE_REP_BIT] = repeater_r;
    ext_view[HWSW_BIT] = sw_mode_r;
    ext_view[RFAULT_BIT] = stat_r.partner_fault;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_req.rd) begin
      unique case (mgmt_req.addr)
        TEN_OPS_ADDR: mgmt_rdata <= ten_view;
        EXT_CTRL_ADDR: mgmt_rdata <= ext_view;
        default: mgmt_rdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // SQE test pulse
  // ****************************************************************
  logic tx_d_r;
  logic [15:0] sqe_cnt_r;
  logic sqe_allow;

  // Node mode in ten_mode leaves SQE on unless inhibited or in full duplex
  assign sqe_allow = !ten_ops_r[SQE_INH_BIT]
    && !stat_r.full_duplex && !repeater_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_d_r <= 1'b0;
      sqe_cnt_r <= 16'h0000;
    end else begin
      tx_d_r <= stat_r.tx_active;
      if (tx_d_r && !stat_r.tx_active && sqe_allow && stat_r.ten_mode) begin
        sqe_cnt_r <= 16'(SQE_CYC);
      end else if (sqe_cnt_r != 16'h0000) begin
        sqe_cnt_r <= sqe_cnt_r - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Link integrity
  // ****************************************************************
  link_state_t link_st_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_st_r <= LNK_FAIL;
    end else if (ten_ops_r[LINK_INH_BIT]) begin
      link_st_r <= LNK_PASS;
    end else begin
      unique case (link_st_r)
        LNK_FAIL: begin
          if (stat_r.rx_valid_data) begin
            link_st_r <= ten_ops_r[SQL_INH_BIT] ? LNK_WAIT_IDLE : LNK_PASS;
          end
        end
        LNK_WAIT_IDLE: begin
          if (stat_r.rx_idle) begin
            link_st_r <= LNK_PASS;
          end
        end
        LNK_PASS: begin
          if (!stat_r.rx_link_pulse && !stat_r.rx_valid_data) begin
            link_st_r <= LNK_FAIL;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Line controls
  // ****************************************************************
  wire logic tri_on = ext_ctrl_r[TRI_BIT];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_ctrl <= '0;
      pair_transmit_pos <= 1'b0;
      pair_transmit_neg <= 1'b0;
      pair_transmit_oe_n <= 1'b1;
    end else begin
      line_ctrl.jabber_check_en <= !ten_ops_r[JAB_INH_BIT];
      // Correction applies at either speed; reception continues anyway
      line_ctrl.rx_pol_correct <= !ten_ops_r[APOL_INH_BIT];
      line_ctrl.link_pass <= (link_st_r == LNK_PASS);
      line_ctrl.carrier_sense <= repeater_r ? stat_r.rx_active
        : (stat_r.tx_active | stat_r.rx_active);
      line_ctrl.collision <= (sqe_cnt_r != 16'h0000);
      line_ctrl.tx_tristate <= tri_on;
      line_ctrl.tx100_power_down <= ext_ctrl_r[APD_BIT] && stat_r.ten_mode;
      pair_transmit_pos <= pair_transmit_pos_in;
      pair_transmit_neg <= pair_transmit_neg_in;
      pair_transmit_oe_n <= tri_on;
    end
  end

endmodule

`default_nettype wire

// ==== mgmt_entity_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mgmt_entity_model (
  input wire logic core_clk, // Core clock
  output phy_ext_pkg::mgmt_req_t mgmt_req, // Requests to the block
  input wire logic [15:0] mgmt_rdata // Read data from the block
);
  import phy_ext_pkg::*;
  // **********
  // Accesses
  // **********
  initial mgmt_req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == TEN_OPS_ADDR) ? ((d & 16'hc02f) | 16'h0010) : (d & 16'he081);
    @(posedge core_clk);
    mgmt_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge core_clk);
    mgmt_req <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    mgmt_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0};
    @(posedge core_clk);
    mgmt_req <= '0;
    @(posedge core_clk);
    #1 d = mgmt_rdata;
  endtask
endmodule
`default_nettype wire

// ==== phy_ext_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module phy_ext_properties #(
  parameter int SQE_CYC = 4
) (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Sync reset
  input wire phy_ext_pkg::mgmt_req_t mgmt_req, // Requests
  input wire phy_ext_pkg::line_stat_t line_stat, // Line status
  input wire logic node_repeater_select, // Mode strap
  input wire logic pair_transmit_oe_n, // Pin enable
  input wire phy_ext_pkg::line_ctrl_t line_ctrl // Controls
);
  import phy_ext_pkg::*;
  // **********
  // Shadows
  // **********
  logic [15:0] ten_s;
  logic [15:0] ext_s;
  int col_len;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ten_s <= TEN_OPS_RESET;
      ext_s <= EXT_CTRL_RESET;
    end else if (mgmt_req.wr && mgmt_req.addr == TEN_OPS_ADDR) begin
      ten_s <= mgmt_req.wdata;
    end else if (mgmt_req.wr && mgmt_req.addr == EXT_CTRL_ADDR) begin
      ext_s <= mgmt_req.wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || !line_ctrl.collision) begin
      col_len <= 0;
    end else begin
      col_len <= col_len + 1;
    end
  end
  // **********
  // Properties
  // **********
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  tri_float_a: assert property (ext_s[7] [*2] |-> pair_transmit_oe_n && line_ctrl.tx_tristate)
    else $error("tristate not applied");
  pol_fix_a: assert property ((line_stat.rx_pol_swapped && !ten_s[3]) [*5]
    |-> line_ctrl.rx_pol_correct) else $error("polarity not corrected");
  jab_off_a: assert property (ten_s[5] [*2] |-> !line_ctrl.jabber_check_en)
    else $error("jabber check not inhibited");
  link_force_a: assert property ((ten_s[1] && line_stat.ten_mode) [*4] |-> line_ctrl.link_pass)
    else $error("link not forced");
  auto_pd_a: assert property ((ext_s[0] && line_stat.ten_mode) [*5]
    |-> line_ctrl.tx100_power_down) else $error("no power down");
  sqe_start_a: assert property ($fell(line_stat.tx_active) && !ten_s[2] && line_stat.ten_mode
    && !line_stat.full_duplex && !node_repeater_select |-> ##[1:8] line_ctrl.collision)
    else $error("sqe pulse missing");
  sqe_len_a: assert property ($fell(line_ctrl.collision) |-> col_len == SQE_CYC)
    else $error("sqe pulse length");
  sqe_duplex_a: assert property (line_stat.full_duplex [*8] |-> !$rose(line_ctrl.collision))
    else $error("sqe in full duplex");
  node_crs_a: assert property ((line_stat.tx_active && !node_repeater_select) [*4]
    |-> line_ctrl.carrier_sense) else $error("carrier sense missing");
  cover property ($rose(line_ctrl.collision));
  cover property ($rose(pair_transmit_oe_n));
  cover property (mgmt_req.wr && mgmt_req.addr == TEN_OPS_ADDR);
endmodule
bind phy_10base_ops_ext_ctrl_regs phy_ext_properties #(.SQE_CYC(SQE_CYC)) props_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .mgmt_req(mgmt_req), .line_stat(line_stat),
  .node_repeater_select(node_repeater_select), .pair_transmit_oe_n(pair_transmit_oe_n),
  .line_ctrl(line_ctrl));
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import phy_ext_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  mgmt_req_t mreq;
  logic [15:0] rdata;
  line_stat_t ls = '{ten_mode: 1'b1, default: 1'b0};
  logic tp = 1'b0;
  logic nrs = 1'b0;
  logic tpp;
  logic tpn;
  logic oe_n;
  line_ctrl_t lc;
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] d;
  int c;
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) tp <= ~tp;
  phy_10base_ops_ext_ctrl_regs #(.SQE_CYC(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .mgmt_req(mreq), .mgmt_rdata(rdata), .line_stat(ls), .node_repeater_select(nrs),
    .sw_mode_pin(1'b1), .pair_transmit_pos_in(tp), .pair_transmit_neg_in(~tp),
    .pair_transmit_pos(tpp), .pair_transmit_neg(tpn), .pair_transmit_oe_n(oe_n), .line_ctrl(lc));
  mgmt_entity_model sta_u (.core_clk(core_clk), .mgmt_req(mreq), .mgmt_rdata(rdata));
  // **********
  // Helpers
  // **********
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [4:0] a, input logic [15:0] e);
    sta_u.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic pulse();
    c = 0;
    @(posedge core_clk) ls.tx_active <= 1'b1;
    repeat (6) @(posedge core_clk);
    ls.tx_active <= 1'b0;
    repeat (16) begin
      @(posedge core_clk);
      #1 c += lc.collision;
    end
  endtask
  task automatic do_reset(input logic pin);
    @(posedge core_clk) begin
      nrs <= pin;
      sys_rst <= 1'b1;
    end
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // **********
  // Scenarios
  // **********
  task automatic t_ext();
    rd_chk("ten reset", TEN_OPS_ADDR, 16'h0010);
    rd_chk("ext reset", EXT_CTRL_ADDR, 16'h4001);
    sta_u.wr(EXT_CTRL_ADDR, 16'he081);
    rd_chk("ext ro", EXT_CTRL_ADDR, 16'h4081);
    chk("oe_n", 16'h1, {15'h0, oe_n});
    chk("pair", 16'h1, {15'h0, tpp ^ tpn});
    sta_u.wr(EXT_CTRL_ADDR, 16'h0001);
    @(posedge core_clk) ls.partner_fault <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk("rfault", EXT_CTRL_ADDR, 16'h6001);
    ls.partner_fault <= 1'b0;
    $display("test ext done");
  endtask
  task automatic t_ten();
    sta_u.wr(TEN_OPS_ADDR, 16'h002f);
    rd_chk("ten rw", TEN_OPS_ADDR, 16'h003f);
    chk("ctl", 16'h0, {13'h0, lc.jabber_check_en, lc.rx_pol_correct, ~lc.link_pass});
    pulse();
    chk("sqe inh", 16'h0, c[15:0]);
    sta_u.wr(TEN_OPS_ADDR, 16'h0010);
    @(posedge core_clk) ls.full_duplex <= 1'b1;
    pulse();
    chk("sqe fdx", 16'h0, c[15:0]);
    rd_chk("sqe bit", TEN_OPS_ADDR, 16'h0010);
    @(posedge core_clk) ls.full_duplex <= 1'b0;
    repeat (4) @(posedge core_clk);
    pulse();
    chk("sqe len", 16'h4, c[15:0]);
    $display("test ten done");
  endtask
  task automatic t_pol();
    @(posedge core_clk) ls.rx_pol_swapped <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("pol fix", 16'h1, {15'h0, lc.rx_pol_correct});
    rd_chk("pol on", TEN_OPS_ADDR, 16'h4010);
    @(posedge core_clk) ls.rx_pol_swapped <= 1'b0;
    repeat (4) @(posedge core_clk);
    sta_u.rd(TEN_OPS_ADDR, d);
    rd_chk("pol off", TEN_OPS_ADDR, 16'h0010);
    $display("test pol done");
  endtask
  task automatic t_link();
    sta_u.wr(TEN_OPS_ADDR, 16'h0011);
    @(posedge core_clk) begin
      ls.rx_link_pulse <= 1'b1;
      ls.rx_valid_data <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    ls.rx_valid_data <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("sql wait", 16'h0, {15'h0, lc.link_pass});
    @(posedge core_clk) ls.rx_idle <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chk("sql pass", 16'h1, {15'h0, lc.link_pass});
    sta_u.wr(TEN_OPS_ADDR, 16'h0010);
    @(posedge core_clk) begin
      ls.rx_idle <= 1'b0;
      ls.rx_link_pulse <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1 chk("link loss", 16'h0, {15'h0, lc.link_pass});
    @(posedge core_clk) ls.rx_valid_data <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chk("sql off", 16'h1, {15'h0, lc.link_pass});
    @(posedge core_clk) ls.rx_valid_data <= 1'b0;
    repeat (4) @(posedge core_clk);
    $display("test link done");
  endtask
  task automatic t_mode();
    do_reset(1'b1);
    rd_chk("ext rep", EXT_CTRL_ADDR, 16'hc001);
    pulse();
    chk("sqe rep", 16'h0, c[15:0]);
    @(posedge core_clk) ls.tx_active <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk("crs rep", 16'h0, {15'h0, lc.carrier_sense});
    @(posedge core_clk) ls.tx_active <= 1'b0;
    do_reset(1'b0);
    rd_chk("ext node", EXT_CTRL_ADDR, 16'h4001);
    @(posedge core_clk) ls.tx_active <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk("crs node", 16'h1, {15'h0, lc.carrier_sense});
    @(posedge core_clk) ls.tx_active <= 1'b0;
    repeat (6) @(posedge core_clk);
    $display("test mode done");
  endtask
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_ext();
    t_ten();
    t_link();
    t_pol();
    t_mode();
    close_out();
  end
endmodule
`default_nettype wire
